// [rtl/dtb_sram_port.sv]
`timescale 1ns/1ps
`default_nettype none

module dtb_sram_port #(
    parameter int ADDR_W = dtb_pkg::ADDR_W_DEF,
    parameter int DATA_W = dtb_pkg::DATA_W_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_stop,
    input wire logic i_single_clk_strap,
    input wire logic i_read_port_select_n,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic i_write_port_select_n,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data_k,
    input wire logic [DATA_W/dtb_pkg::LANE_W-1:0] i_byte_lane_write_select_n_k,
    input wire logic [DATA_W-1:0] i_wr_data_kn,
    input wire logic [DATA_W/dtb_pkg::LANE_W-1:0] i_byte_lane_write_select_n_kn,
    output logic o_wr_ready,
    output logic [DATA_W-1:0] o_rd_data_c_n,
    output logic o_rd_oe_c_n,
    output logic [DATA_W-1:0] o_rd_data_c,
    output logic o_rd_oe_c,
    output logic o_single_clk_mode
);
    import dtb_pkg::*;

    localparam int LANES = DATA_W / LANE_W;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] sel_b_n;
        logic [DATA_W-1:0] data_b;
        logic [LANES-1:0] sel_a_n;
        logic [DATA_W-1:0] data_a;
    } dtb_wr_entry_t;

    typedef struct packed {
        logic hi_pend;
        logic [ADDR_W-1:0] hi_addr;
        logic [DATA_W-1:0] q_c_n;
        logic [DATA_W-1:0] q_c;
        logic oe_c_n;
        logic oe_c;
        dtb_mode_t mode;
        logic strap_taken;
    } dtb_state_t;

    localparam int EW = $bits(dtb_wr_entry_t);

    dtb_state_t s;
    dtb_state_t next_s;
    logic [DATA_W-1:0] mem [0:2**(ADDR_W+1)-1];
    dtb_wr_entry_t wr_in;
    dtb_wr_entry_t drain;
    dtb_wr_entry_t [WBUF_DEPTH-1:0] ents;
    logic [WBUF_DEPTH-1:0] ent_valid;
    logic buf_in_ready;
    logic drain_valid;
    logic drain_go;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0] sel_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int l = 0; l < LANES; l++) begin
            if (!sel_n[l]) begin
                r[l*LANE_W +: LANE_W] = new_w[l*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    // Array word overlaid with queued writes, oldest first, so newest wins
    function automatic logic [DATA_W-1:0] newest(input logic [ADDR_W:0] wa);
        logic [DATA_W-1:0] r;
        r = mem[wa];
        for (int i = 0; i < WBUF_DEPTH; i++) begin
            if (ent_valid[i] && ents[i].addr == wa[ADDR_W:1]) begin
                r = (wa[0] == BURST_OFS_HI) ? lane_merge(r, ents[i].data_b, ents[i].sel_b_n)
                                            : lane_merge(r, ents[i].data_a, ents[i].sel_a_n);
            end
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Write port
    // ---------------------------------------------------------------
    // both phases: the two halves and their masks arrive together
    assign wr_in = '{addr: i_wr_addr,
                     sel_b_n: i_byte_lane_write_select_n_kn,
                     data_b: i_wr_data_kn,
                     sel_a_n: i_byte_lane_write_select_n_k,
                     data_a: i_wr_data_k};
    assign o_wr_ready = buf_in_ready && !i_clk_stop;
    // clock stopped: the array commit stalls too
    assign drain_go = drain_valid && !i_clk_stop;

    dtb_wr_buffer #(
        .W(EW),
        .DEPTH(WBUF_DEPTH)
    ) u_wr_buffer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(!i_write_port_select_n && !i_clk_stop),
        .i_in_data(wr_in),
        .o_in_ready(buf_in_ready),
        .o_out_valid(drain_valid),
        .o_out_data(drain),
        .i_out_ready(!i_clk_stop),
        .o_entries(ents),
        .o_ent_valid(ent_valid)
    );

    // Array commit, one whole burst per cycle
    always_ff @(posedge i_sys_clk) begin
        if (drain_go) begin
            // burst order: first half to A+0
            // all lanes masked: no write to A+0
            if (!(&drain.sel_a_n)) begin
                mem[{drain.addr, BURST_OFS_LO}] <=
                    lane_merge(mem[{drain.addr, BURST_OFS_LO}], drain.data_a, drain.sel_a_n);
            end
            // second half uses its own mask
            // all lanes masked: word left as is
            if (!(&drain.sel_b_n)) begin
                mem[{drain.addr, BURST_OFS_HI}] <=
                    lane_merge(mem[{drain.addr, BURST_OFS_HI}], drain.data_b, drain.sel_b_n);
            end
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        next_s = s;
        // strap caught once after reset release, fixed from then on
        if (!s.strap_taken) begin
            next_s.strap_taken = 1'b1;
            next_s.mode = i_single_clk_strap ? DTB_MODE_SINGLE_CLK : DTB_MODE_DUAL_CLK;
        end
        // stopped clock: outputs and pipeline frozen
        if (!i_clk_stop) begin
            // outputs drop unless a new word is due
            next_s.oe_c_n = 1'b0;
            next_s.oe_c = 1'b0;
            next_s.hi_pend = 1'b0;
            // first word on the complementary phase of t+1
            if (!i_read_port_select_n) begin
                // address latched once for the burst
                next_s.hi_pend = 1'b1;
                next_s.hi_addr = i_rd_addr;
                next_s.q_c_n = newest({i_rd_addr, BURST_OFS_LO});
                next_s.oe_c_n = 1'b1;
            end
            // second word on the true phase of t+2
            if (s.hi_pend) begin
                next_s.q_c = newest({s.hi_addr, BURST_OFS_HI});
                next_s.oe_c = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{hi_pend: RST_PEND, hi_addr: '0, q_c_n: '0, q_c: '0,
                   oe_c_n: RST_OE, oe_c: RST_OE, mode: DTB_MODE_DUAL_CLK,
                   strap_taken: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign o_rd_data_c_n = s.q_c_n;
    assign o_rd_data_c = s.q_c;
    assign o_rd_oe_c_n = s.oe_c_n;
    assign o_rd_oe_c = s.oe_c;
    assign o_single_clk_mode = (s.mode == DTB_MODE_SINGLE_CLK);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic [DATA_W-1:0] drain_old_lo;
    logic [DATA_W-1:0] drain_old_hi;
    assign drain_old_lo = mem[{drain.addr, BURST_OFS_LO}];
    assign drain_old_hi = mem[{drain.addr, BURST_OFS_HI}];

    sequence rd_start;
        !i_read_port_select_n && !i_clk_stop;
    endsequence

    sequence full_write_lo;
        !i_write_port_select_n && o_wr_ready && !(|i_byte_lane_write_select_n_k);
    endsequence

    chk_read_lo_slot: assert property (rd_start |=> o_rd_oe_c_n)
        else $error("first read word not driven in next cycle");

    chk_read_hi_slot: assert property (rd_start ##1 !i_clk_stop |=> o_rd_oe_c)
        else $error("second read word not driven two cycles on");

    chk_burst_addr: assert property (rd_start |=> s.hi_addr == $past(i_rd_addr))
        else $error("burst address not latched at read start");

    chk_idle_hiz: assert property (
        i_read_port_select_n && !s.hi_pend && !i_clk_stop |=> !o_rd_oe_c_n && !o_rd_oe_c)
        else $error("read outputs driven while deselected");

    chk_burst_end_hiz: assert property (
        o_rd_oe_c && !o_rd_oe_c_n && !i_clk_stop |=> !o_rd_oe_c)
        else $error("outputs not released after second word");

    chk_stop_freeze: assert property (i_clk_stop |=> $stable(o_rd_oe_c_n) && $stable(o_rd_oe_c)
        && $stable(o_rd_data_c_n) && $stable(o_rd_data_c))
        else $error("outputs moved while clock stopped");

    chk_forward_newest: assert property (full_write_lo ##1 (rd_start
        and i_rd_addr == $past(i_wr_addr)) |=> o_rd_data_c_n == $past(i_wr_data_k, 2))
        else $error("read missed write from previous cycle");

    chk_masked_lo_keep: assert property (drain_go && (&drain.sel_a_n)
        |=> mem[{$past(drain.addr), BURST_OFS_LO}] == $past(drain_old_lo))
        else $error("fully masked first half changed the array");

    chk_lane0_write: assert property (drain_go && !drain.sel_b_n[0]
        |=> mem[{$past(drain.addr), BURST_OFS_HI}][LANE_W-1:0]
            == $past(drain.data_b[LANE_W-1:0]))
        else $error("enabled lane of second half not written");

    chk_lane_keep: assert property (drain_go && drain.sel_b_n[LANES-1]
        |=> mem[{$past(drain.addr), BURST_OFS_HI}][DATA_W-1 -: LANE_W]
            == $past(drain_old_hi[DATA_W-1 -: LANE_W]))
        else $error("masked lane of second half altered");

    chk_write_taken: assert property (!i_write_port_select_n && o_wr_ready
        |=> drain_valid)
        else $error("accepted write not queued");
endmodule

`default_nettype wire

// [rtl/dtb_pkg.sv]
`default_nettype none

package dtb_pkg;
    // ---------------------------------------------------------------
    // Organisation
    // ---------------------------------------------------------------
    localparam int LANE_W = 9;
    localparam int ADDR_W_DEF = 21;
    localparam int DATA_W_DEF = 18;
    localparam int WBUF_DEPTH = 2;

    // ---------------------------------------------------------------
    // Burst order and read timing
    // ---------------------------------------------------------------
    localparam logic [0:0] BURST_OFS_LO = 1'h0;
    localparam logic [0:0] BURST_OFS_HI = 1'h1;
    localparam int RD_LO_LAT = 1;
    localparam int RD_HI_LAT = 2;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic RST_OE = 1'h0;
    localparam logic RST_PEND = 1'h0;

    typedef enum logic {
        DTB_MODE_DUAL_CLK,
        DTB_MODE_SINGLE_CLK
    } dtb_mode_t;
endpackage

`default_nettype wire

// [rtl/dtb_wr_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module dtb_wr_buffer #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    input wire logic [W-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [W-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [DEPTH*W-1:0] o_entries,
    output logic [DEPTH-1:0] o_ent_valid
);
    import dtb_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] ent;
        logic [CW-1:0] count;
    } dtb_buf_state_t;

    dtb_buf_state_t s;
    dtb_buf_state_t next_s;
    logic pop;
    logic push;

    // ---------------------------------------------------------------
    // Shift register, index 0 oldest
    // ---------------------------------------------------------------
    // Ready ignores a same-cycle pop: honest full, no combinational path
    assign o_in_ready = (s.count != CW'(DEPTH));
    assign o_out_valid = (s.count != '0);
    assign o_out_data = s.ent[0];
    assign o_entries = s.ent;
    assign pop = o_out_valid && i_out_ready;
    assign push = i_in_valid && o_in_ready;

    always_comb begin
        next_s = s;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_s.ent[i] = s.ent[i+1];
            end
        end
        if (push) begin
            next_s.ent[s.count - CW'(pop)] = i_in_data;
        end
        next_s.count = s.count + CW'(push) - CW'(pop);
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            o_ent_valid[i] = (CW'(i) < s.count);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

`default_nettype wire

// [test/dtb_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dtb_ctrl_model #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 18,
    parameter int LANES = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_wr_ready,
    output logic o_read_port_select_n,
    output logic [ADDR_W-1:0] o_rd_addr,
    output logic o_write_port_select_n,
    output logic [ADDR_W-1:0] o_wr_addr,
    output logic [DATA_W-1:0] o_wr_data_k,
    output logic [LANES-1:0] o_sel_k,
    output logic [DATA_W-1:0] o_wr_data_kn,
    output logic [LANES-1:0] o_sel_kn
);
    // ---------------------------------------------------------------
    // Controller side of the port
    // ---------------------------------------------------------------
    initial begin
        o_read_port_select_n = 1'b1;
        o_write_port_select_n = 1'b1;
        o_rd_addr = '0;
        o_wr_addr = '0;
        o_wr_data_k = '0;
        o_sel_k = '0;
        o_wr_data_kn = '0;
        o_sel_kn = '0;
    end

    // both halves, own masks
    // Request stays up past its edge so back to back calls need no gap
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dk,
        input logic [LANES-1:0] sk, input logic [DATA_W-1:0] dkn, input logic [LANES-1:0] skn);
        int n;
        n = 0;
        o_wr_addr = a;
        o_wr_data_k = dk;
        o_sel_k = sk;
        o_wr_data_kn = dkn;
        o_sel_kn = skn;
        o_write_port_select_n = 1'b0;
        while (i_wr_ready !== 1'b1 && n < 64) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        @(posedge i_sys_clk);
        #1;
    endtask

    // A read closes a write left standing, so no stale write repeats at its edge
    task automatic do_read(input logic [ADDR_W-1:0] a);
        o_write_port_select_n = 1'b1;
        o_rd_addr = a;
        o_read_port_select_n = 1'b0;
        @(posedge i_sys_clk);
        #1;
    endtask

    // idle selects high
    // Released lines never repeat the last value, so stale data cannot pass
    task automatic idle();
        o_read_port_select_n = 1'b1;
        o_write_port_select_n = 1'b1;
        o_rd_addr = ~o_rd_addr;
        o_wr_addr = ~o_wr_addr;
        o_wr_data_k = ~o_wr_data_k;
        o_sel_k = ~o_sel_k;
        o_wr_data_kn = ~o_wr_data_kn;
        o_sel_kn = ~o_sel_kn;
    endtask
endmodule

`default_nettype wire

// [test/ddr_two_word_burst_sram_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module ddr_two_word_burst_sram_port_tb;
    localparam int AW = 21;
    localparam int DW = 18;
    localparam int LN = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_stop = 1'b0;
    logic strap = 1'b0;
    logic rps_n, wps_n, wr_ready, oe_cn, oe_c, single_mode;
    logic [AW-1:0] rd_addr, wr_addr;
    logic [DW-1:0] dk, dkn, q_cn, q_c;
    logic [LN-1:0] sk, skn;
    logic [DW-1:0] mem [int];
    int n_errors = 0;
    int tests_run = 0;
    localparam int WW = 36;
    localparam int WL = 4;
    logic w_rps_n, w_wps_n, w_ready, w_oe_cn, w_oe_c;
    logic [7:0] w_rd_addr, w_wr_addr;
    logic [WW-1:0] w_dk, w_dkn, w_q_cn, w_q_c;
    logic [WL-1:0] w_sk, w_skn;

    always #2 clk = ~clk;

    dtb_sram_port #(.ADDR_W(AW), .DATA_W(DW)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_clk_stop(clk_stop), .i_single_clk_strap(strap), .i_read_port_select_n(rps_n),
        .i_rd_addr(rd_addr), .i_write_port_select_n(wps_n), .i_wr_addr(wr_addr),
        .i_wr_data_k(dk), .i_byte_lane_write_select_n_k(sk), .i_wr_data_kn(dkn),
        .i_byte_lane_write_select_n_kn(skn), .o_wr_ready(wr_ready), .o_rd_data_c_n(q_cn),
        .o_rd_oe_c_n(oe_cn), .o_rd_data_c(q_c), .o_rd_oe_c(oe_c), .o_single_clk_mode(single_mode));

    dtb_ctrl_model #(.ADDR_W(AW), .DATA_W(DW), .LANES(LN)) u_ctrl (.i_sys_clk(clk),
        .i_wr_ready(wr_ready), .o_read_port_select_n(rps_n), .o_rd_addr(rd_addr),
        .o_write_port_select_n(wps_n), .o_wr_addr(wr_addr), .o_wr_data_k(dk), .o_sel_k(sk),
        .o_wr_data_kn(dkn), .o_sel_kn(skn));

    // Wide organisation on a small array keeps the bench light
    dtb_sram_port #(.ADDR_W(8), .DATA_W(WW)) u_dut_wide (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_clk_stop(clk_stop), .i_single_clk_strap(strap), .i_read_port_select_n(w_rps_n),
        .i_rd_addr(w_rd_addr), .i_write_port_select_n(w_wps_n), .i_wr_addr(w_wr_addr),
        .i_wr_data_k(w_dk), .i_byte_lane_write_select_n_k(w_sk), .i_wr_data_kn(w_dkn),
        .i_byte_lane_write_select_n_kn(w_skn), .o_wr_ready(w_ready), .o_rd_data_c_n(w_q_cn),
        .o_rd_oe_c_n(w_oe_cn), .o_rd_data_c(w_q_c), .o_rd_oe_c(w_oe_c), .o_single_clk_mode());

    dtb_ctrl_model #(.ADDR_W(8), .DATA_W(WW), .LANES(WL)) u_ctrl_wide (.i_sys_clk(clk),
        .i_wr_ready(w_ready), .o_read_port_select_n(w_rps_n), .o_rd_addr(w_rd_addr),
        .o_write_port_select_n(w_wps_n), .o_wr_addr(w_wr_addr), .o_wr_data_k(w_dk),
        .o_sel_k(w_sk), .o_wr_data_kn(w_dkn), .o_sel_kn(w_skn));

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
        input logic [LN-1:0] sel_n);
        logic [DW-1:0] r;
        r = old;
        for (int l = 0; l < LN; l++) begin
            if (sel_n[l] == 1'b0) begin
                r[l*9 +: 9] = nw[l*9 +: 9];
            end
        end
        return r;
    endfunction

    task automatic wr(input int a, input logic [DW-1:0] d0, input logic [LN-1:0] s0,
        input logic [DW-1:0] d1, input logic [LN-1:0] s1);
        mem[2*a] = merge(mem.exists(2*a) ? mem[2*a] : '0, d0, s0);
        mem[2*a+1] = merge(mem.exists(2*a+1) ? mem[2*a+1] : '0, d1, s1);
        u_ctrl.do_write(AW'(a), d0, s0, d1, s1);
    endtask

    task automatic rd_chk(input int a);
        u_ctrl.do_read(AW'(a));
        u_ctrl.idle();
        `CHK(oe_cn, 1'b1)
        `CHK(q_cn, mem[2*a])
        @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c}, 2'h1)
        `CHK(q_c, mem[2*a+1])
        @(posedge clk);
        #1;
        `CHK(oe_c, 1'b0)
    endtask

    task automatic settle();
        u_ctrl.idle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        `CHK({oe_cn, oe_c}, 2'h0)
        `CHK(single_mode, 1'b0)
    endtask

    task automatic t_masks();
        for (int m = 0; m < 4; m++) begin
            wr(9, 18'h3FFFF, 2'h0, 18'h3FFFF, 2'h0);
            wr(9, 18'h00000, LN'(m), 18'h0A5A5, ~LN'(m));
            settle();
            rd_chk(9);
        end
    endtask

    task automatic t_b2b();
        wr(16, 18'h11111, 2'h0, 18'h22222, 2'h0);
        wr(17, 18'h33333, 2'h0, 18'h04444, 2'h0);
        settle();
        u_ctrl.do_read(21'h10);
        u_ctrl.do_read(21'h11);
        u_ctrl.idle();
        `CHK({oe_cn, oe_c, q_cn, q_c}, {2'h3, 18'h33333, 18'h22222})
        @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c, q_c}, {2'h1, 18'h04444})
        @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c}, 2'h0)
    endtask

    task automatic t_fwd();
        wr(40, 18'h12345, 2'h0, 18'h2BCDE, 2'h0);
        settle();
        wr(40, 18'h0F0F0, 2'h0, 18'h30303, 2'h0);
        u_ctrl.do_read(21'h28);
        u_ctrl.idle();
        `CHK(q_cn, 18'h0F0F0)
        @(posedge clk);
        #1;
        `CHK(q_c, 18'h30303)
    endtask

    // Wide organisation: lanes 1 and 3 of the first half, second half fully masked
    task automatic t_wide();
        u_ctrl_wide.do_write(8'h03, 36'hFFFFFFFFF, 4'h0, 36'hFFFFFFFFF, 4'h0);
        u_ctrl_wide.do_write(8'h03, 36'h000000000, 4'h5, 36'h123456789, 4'hF);
        u_ctrl_wide.idle();
        repeat (3) @(posedge clk);
        #1;
        u_ctrl_wide.do_read(8'h03);
        u_ctrl_wide.idle();
        `CHK({w_oe_cn, w_q_cn}, {1'b1, 36'h007FC01FF})
        @(posedge clk);
        #1;
        `CHK({w_oe_c, w_q_c}, {1'b1, 36'hFFFFFFFFF})
    endtask

    task automatic t_nop_stop();
        repeat (4) begin
            u_ctrl.idle();
            @(posedge clk);
            #1;
            `CHK({oe_cn, oe_c}, 2'h0)
        end
        u_ctrl.do_read(21'h28);
        u_ctrl.idle();
        clk_stop = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c, wr_ready, q_cn}, {3'h4, 18'h0F0F0})
        clk_stop = 1'b0;
        @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c, q_c}, {2'h1, 18'h30303})
        @(posedge clk);
        #1;
    endtask

    task automatic t_strap();
        strap = 1'b1;
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        `CHK({oe_cn, oe_c}, 2'h0)
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(single_mode, 1'b1)
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        wr(5, 18'h2A5A5, 2'h0, 18'h15A5A, 2'h0);
        settle();
        rd_chk(5);
        t_masks();
        t_b2b();
        t_fwd();
        t_wide();
        t_nop_stop();
        rd_chk(5);
        t_strap();
        finish_test();
    end

    // Whole run is under a hundred cycles; this is far past it
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end
endmodule

`default_nettype wire
